/* rtl/dpc_pkg.sv */
// shared constants, types and helpers for the dma read prefetch cache
// assumes a 22-bit physical word address with a byte-select bit 0
// What this block does
// - four sets, each eight 16-bit words, one valid bit, one 18-bit tag
// - address bits 21:4 form the tag, bits 3:1 the word index
// - bit 0 selects write byte; ignored for dma
// - data ram holds set a at 00-07, then b, c, d up to octal 37
// - while either enable bit is clear: valids cleared, order reset to a,b,c,d
// - disable or init leaves data and tag contents untouched
// - cache works only with cache enable and relocation enable both set
// - cpu or dma write hitting a valid set invalidates it, makes it next
// - dma read checks tag hit on valid sets and whether index is zero
// - miss with nonzero index: return memory word, cache unchanged
// - miss with zero index: load tag into next set, forward memory word
// - fill reads the addressed word and next seven into the next set
// - clean fill sets valid and makes the set least available
// - parity error during fill: stays invalid and next; no own error flag
// - read hit returns stored word by set and index, no memory read
// - hit on index 7 invalidates the set and makes it next
// - hit on other index keeps it valid, makes it least available
// - power-low condition clears the memory configuration register
// - relocation enable is bit 5 of register three; clearing it disables cache
package dpc_pkg;

    localparam int          ADDR_W      = 22;
    localparam int          WORD_W      = 16;
    localparam int          TAG_W       = 18;
    localparam int          TAG_LO      = 4;
    localparam int          IDX_LO      = 1;
    localparam int          RAM_AW      = 5;
    localparam logic [2:0]  LAST_IDX    = 3'h7;
    localparam logic [7:0]  ORDER_INIT  = 8'he4;

    // register map, byte addresses
    localparam int          AXI_AW      = 12;
    localparam logic [11:0] REG_MCR     = 12'h000;
    localparam logic [11:0] REG_MEM_MGMT_REG_THREE    = 12'h004;
    localparam logic [11:0] REG_STAT    = 12'h008;
    localparam int          MCR_W       = 7;
    localparam int          MCR_CACHE_EN = 6;
    localparam int          MEM_MGMT_REG_THREE_RELOC  = 5;
    localparam logic [6:0]  MCR_RST     = 7'h00;
    localparam logic [15:0] MEM_MGMT_REG_THREE_RST    = 16'h0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_HIT, ST_MEM, ST_FILL} dpc_state_t;

    function automatic logic [TAG_W-1:0] dpc_tag(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:TAG_LO];
    endfunction

    function automatic logic [2:0] dpc_idx(input logic [ADDR_W-1:0] a);
        return a[TAG_LO-1:IDX_LO];
    endfunction

    // slot 0 of the order list is the next available set
    function automatic logic [7:0] dpc_front(input logic [7:0] ord, input logic [1:0] s);
        logic [7:0] r;
        int         k;
        r = 8'h00;
        r[1:0] = s;
        k = 1;
        for (int i = 0; i < 4; i++) begin
            if (ord[2*i +: 2] != s) begin
                r[2*k +: 2] = ord[2*i +: 2];
                k++;
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] dpc_back(input logic [7:0] ord, input logic [1:0] s);
        logic [7:0] r;
        int         k;
        r = 8'h00;
        r[7:6] = s;
        k = 0;
        for (int i = 0; i < 4; i++) begin
            if (ord[2*i +: 2] != s) begin
                r[2*k +: 2] = ord[2*i +: 2];
                k++;
            end
        end
        return r;
    endfunction

endpackage

/* rtl/dpc_ram_if.sv */
// port bundle between the cache control and its data ram
// assumes one writer and one reader, same clock
`timescale 1ns/1ps
interface dpc_ram_if;
    logic        we;
    logic [4:0]  waddr;
    logic [15:0] wdata;
    logic [4:0]  raddr;
    logic [15:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport ram  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* rtl/dpc_data_ram.sv */
// thirty-two word data store, one registered read port, one write port
// assumes the controller holds raddr during the cycle before it reads
`timescale 1ns/1ps
module dpc_data_ram
    import dpc_pkg::*;
(
    // clock
    input wire logic clk,
    // access
    dpc_ram_if.ram   port
);
    // no reset on purpose: contents survive disable
    logic [WORD_W-1:0] mem_q [32];

    always_ff @(posedge clk) begin
        if (port.we) begin
            mem_q[port.waddr] <= port.wdata;
        end
    end

    always_ff @(posedge clk) begin
        port.rdata <= mem_q[port.raddr];
    end
endmodule

/* rtl/dpc_top.sv */
// dma read prefetch cache with axi4-lite control registers
// assumes memory answers one word per mem_rd_ack while mem_rd_req is high
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dpc_top
    import dpc_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              pwr_low,
    // axi4-lite slave
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // dma read requests from peripheral devices
    input  wire logic              dma_rd_valid,
    input  wire logic [ADDR_W-1:0] dma_rd_addr,
    output logic                   dma_rd_ready,
    output logic                   dma_rd_done,
    output logic [WORD_W-1:0]      dma_rd_data,
    // write snoop from the memory bus
    input  wire logic              snoop_wr_valid,
    input  wire logic [ADDR_W-1:0] snoop_wr_addr,
    // main memory read port
    output logic                   mem_rd_req,
    output logic [ADDR_W-1:0]      mem_rd_addr,
    input  wire logic              mem_rd_ack,
    input  wire logic [WORD_W-1:0] mem_rd_data,
    input  wire logic              mem_rd_perr
);
    dpc_ram_if ram_bus ();

    dpc_state_t        state_q;
    logic [MCR_W-1:0]  mcr_q;
    logic [15:0]       mem_mgmt_reg_three_q;
    logic [TAG_W-1:0]  tag_q [4];
    logic [3:0]        valid_q;
    logic [3:0]        valid_d;
    logic [7:0]        order_q;
    logic [7:0]        order_d;
    logic [1:0]        fill_set_q;
    logic [2:0]        fill_cnt_q;
    logic              fill_bad_q;
    logic              cache_on;
    logic [3:0]        rd_hit;
    logic [3:0]        sn_hit;
    logic [1:0]        hit_set;
    logic              take;
    logic              hit_take;
    logic              fill_start;
    logic              fill_word;
    logic              fill_end;
    logic              fill_ok;
    logic              sn_fill_hit;
    logic              aw_have_q;
    logic              w_have_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              wr_fire;

    assign cache_on = mcr_q[MCR_CACHE_EN] & mem_mgmt_reg_three_q[MEM_MGMT_REG_THREE_RELOC];

    function automatic logic [3:0] tag_match(input logic [TAG_W-1:0] t);
        logic [3:0] m;
        m = 4'h0;
        for (int s = 0; s < 4; s++) begin
            m[s] = valid_q[s] && (tag_q[s] == t);
        end
        return m;
    endfunction

    // tags compared in full; byte bit never reaches the compare
    assign rd_hit = tag_match(dpc_tag(dma_rd_addr));
    assign sn_hit = (snoop_wr_valid && cache_on) ? tag_match(dpc_tag(snoop_wr_addr)) : 4'h0;
    assign sn_fill_hit = snoop_wr_valid && (state_q == ST_FILL)
                         && (tag_q[fill_set_q] == dpc_tag(snoop_wr_addr));

    always_comb begin
        hit_set = 2'h0;
        for (int s = 0; s < 4; s++) begin
            if (rd_hit[s]) begin
                hit_set = s[1:0];
            end
        end
    end

    assign take       = (state_q == ST_IDLE) && dma_rd_valid && dma_rd_ready;
    assign hit_take   = take && cache_on && (rd_hit != 4'h0);
    assign fill_start = take && cache_on && (rd_hit == 4'h0)
                        && (dpc_idx(dma_rd_addr) == 3'h0);
    assign fill_word  = (state_q == ST_FILL) && mem_rd_ack;
    assign fill_end   = fill_word && (fill_cnt_q == LAST_IDX);
    // any parity fault, snoop or disable spoils the block
    assign fill_ok    = fill_end && cache_on && !fill_bad_q && !mem_rd_perr
                        && !sn_fill_hit;

    // data ram hookup: set picks the block of eight, index the word
    assign ram_bus.we    = fill_word;
    assign ram_bus.waddr = {fill_set_q, fill_cnt_q};
    assign ram_bus.wdata = mem_rd_data;
    assign ram_bus.raddr = {hit_set, dpc_idx(dma_rd_addr)};

    dpc_data_ram u_ram (
        .clk  (clk),
        .port (ram_bus)
    );

    // request sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q      <= ST_IDLE;
            dma_rd_ready <= 1'b1;
            dma_rd_done  <= 1'b0;
            dma_rd_data  <= 16'h0000;
            mem_rd_req   <= 1'b0;
            mem_rd_addr  <= 22'h000000;
            fill_set_q   <= 2'h0;
            fill_cnt_q   <= 3'h0;
            fill_bad_q   <= 1'b0;
        end else begin
            dma_rd_done <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        dma_rd_ready <= 1'b0;
                        if (hit_take) begin
                            state_q <= ST_HIT;
                        end else if (fill_start) begin
                            state_q     <= ST_FILL;
                            fill_set_q  <= order_q[1:0];
                            fill_cnt_q  <= 3'h0;
                            fill_bad_q  <= 1'b0;
                            mem_rd_req  <= 1'b1;
                            mem_rd_addr <= dma_rd_addr;
                        end else begin
                            state_q     <= ST_MEM;
                            mem_rd_req  <= 1'b1;
                            mem_rd_addr <= dma_rd_addr;
                        end
                    end
                end
                ST_HIT: begin
                    dma_rd_data  <= ram_bus.rdata;
                    dma_rd_done  <= 1'b1;
                    dma_rd_ready <= 1'b1;
                    state_q      <= ST_IDLE;
                end
                ST_MEM: begin
                    if (mem_rd_ack) begin
                        mem_rd_req   <= 1'b0;
                        dma_rd_data  <= mem_rd_data;
                        dma_rd_done  <= 1'b1;
                        dma_rd_ready <= 1'b1;
                        state_q      <= ST_IDLE;
                    end
                end
                ST_FILL: begin
                    // a snoop on any word of the block spoils it, not only on the last
                    if (sn_fill_hit) begin
                        fill_bad_q <= 1'b1;
                    end
                    if (mem_rd_ack) begin
                        if (fill_cnt_q == 3'h0) begin
                            dma_rd_data <= mem_rd_data;
                            dma_rd_done <= 1'b1;
                        end
                        if (mem_rd_perr) begin
                            fill_bad_q <= 1'b1;
                        end
                        if (fill_cnt_q == LAST_IDX) begin
                            mem_rd_req   <= 1'b0;
                            dma_rd_ready <= 1'b1;
                            state_q      <= ST_IDLE;
                        end else begin
                            fill_cnt_q <= fill_cnt_q + 3'h1;
                            mem_rd_addr[TAG_LO-1:IDX_LO] <= fill_cnt_q + 3'h1;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // tags keep their contents across reset and disable
    always_ff @(posedge clk) begin
        if (fill_start) begin
            tag_q[order_q[1:0]] <= dpc_tag(dma_rd_addr);
        end
    end

    // valid bits and replacement order; later steps take precedence
    always_comb begin
        valid_d = valid_q;
        order_d = order_q;
        // a replaced set must not stay valid under its new tag
        if (fill_start) begin
            valid_d[order_q[1:0]] = 1'b0;
        end
        if (hit_take) begin
            if (dpc_idx(dma_rd_addr) == LAST_IDX) begin
                valid_d[hit_set] = 1'b0;
                order_d = dpc_front(order_d, hit_set);
            end else begin
                order_d = dpc_back(order_d, hit_set);
            end
        end
        if (fill_ok) begin
            valid_d[fill_set_q] = 1'b1;
            order_d = dpc_back(order_d, fill_set_q);
        end else if (fill_end || sn_fill_hit) begin
            order_d = dpc_front(order_d, fill_set_q);
        end
        for (int s = 0; s < 4; s++) begin
            if (sn_hit[s]) begin
                valid_d[s] = 1'b0;
                order_d = dpc_front(order_d, s[1:0]);
            end
        end
        if (!cache_on) begin
            valid_d = 4'h0;
            order_d = ORDER_INIT;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            valid_q <= 4'h0;
            order_q <= ORDER_INIT;
        end else begin
            valid_q <= valid_d;
            order_q <= order_d;
        end
    end

    // axi4-lite write path: address and data taken in either order
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            awaddr_q      <= 12'h000;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q == REG_MCR || awaddr_q == REG_MEM_MGMT_REG_THREE
                                 || awaddr_q == REG_STAT) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // control registers; power-low beats a software write to the configuration register only
    always_ff @(posedge clk) begin
        if (sys_rst || pwr_low) begin
            mcr_q <= MCR_RST;
        end else if (wr_fire && awaddr_q == REG_MCR && wstrb_q[0]) begin
            mcr_q <= wdata_q[MCR_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_mgmt_reg_three_q <= MEM_MGMT_REG_THREE_RST;
        end else if (wr_fire && awaddr_q == REG_MEM_MGMT_REG_THREE) begin
            if (wstrb_q[0]) begin
                mem_mgmt_reg_three_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
                mem_mgmt_reg_three_q[15:8] <= wdata_q[15:8];
            end
        end
    end

    // axi4-lite read path, one read outstanding
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                case (s_axi_araddr)
                    REG_MCR:  s_axi_rdata <= {25'h0000000, mcr_q};
                    REG_MEM_MGMT_REG_THREE: s_axi_rdata <= {16'h0000, mem_mgmt_reg_three_q};
                    REG_STAT: s_axi_rdata <= {19'h00000, state_q != ST_IDLE,
                                              order_q, valid_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_disable_flush: assert property (!cache_on |=> valid_q == 4'h0 && order_q == ORDER_INIT)
        else $error("disable did not flush valids and order");
    a_bypass_when_off: assert property (take && !cache_on |=> state_q == ST_MEM)
        else $error("disabled cache did not bypass to memory");
    a_snoop_kills: assert property (sn_hit != 4'h0 |=> (valid_q & $past(sn_hit)) == 4'h0)
        else $error("snooped write left a set valid");
    a_hit_no_mem: assert property (hit_take |=> !mem_rd_req ##1 dma_rd_done && !mem_rd_req)
        else $error("read hit touched memory or answered late");
    a_last_word_frees: assert property (hit_take && dpc_idx(dma_rd_addr) == LAST_IDX
        |=> !valid_q[$past(hit_set)] && order_q[1:0] == $past(hit_set))
        else $error("index seven hit did not free the set");
    a_mid_hit_keeps: assert property (hit_take && dpc_idx(dma_rd_addr) != LAST_IDX
        && sn_hit == 4'h0 |=> valid_q[$past(hit_set)] && order_q[7:6] == $past(hit_set))
        else $error("hit below seven lost the set or its rank");
    a_fill_commits: assert property (fill_ok
        |=> valid_q[$past(fill_set_q)] && order_q[7:6] == $past(fill_set_q))
        else $error("clean fill not committed");
    a_bad_fill_next: assert property (fill_end && (mem_rd_perr || fill_bad_q)
        |=> !valid_q[$past(fill_set_q)])
        else $error("fill with parity fault became valid");
    a_fill_in_block: assert property (ram_bus.we |-> state_q == ST_FILL
        && ram_bus.waddr == {fill_set_q, mem_rd_addr[TAG_LO-1:IDX_LO]})
        else $error("ram written outside the filling set");
    a_miss_no_write: assert property (state_q == ST_MEM |-> !ram_bus.we)
        else $error("nonzero index miss changed cache data");
    a_tag_loaded: assert property (fill_start
        |=> tag_q[$past(order_q[1:0])] == $past(dpc_tag(dma_rd_addr)))
        else $error("fill did not load the tag");
    a_pwr_low_clear: assert property (pwr_low |=> mcr_q == MCR_RST)
        else $error("power-low did not clear config register");
endmodule

/* verif/dpc_mem_model.sv */
// main memory model answering the cache's word reads
// assumes the cache's clock and reset; one read request at a time
`timescale 1ns/1ps
module dpc_mem_model
    import dpc_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // read port
    input  wire logic              req,
    input  wire logic [ADDR_W-1:0] addr,
    output logic                   ack,
    output logic [WORD_W-1:0]      data,
    output logic                   perr,
    // bench control and count
    input  wire logic              slow,
    input  wire logic              perr_en,
    input  wire logic [2:0]        perr_idx,
    output logic [15:0]            acks
);
    logic [1:0] wait_q;

    // between answers data and parity toggle, so a stale sample never passes
    always_ff @(posedge clk) begin
        if (rst) begin
            ack    <= 1'b0;
            data   <= 16'h0000;
            perr   <= 1'b0;
            acks   <= 16'h0000;
            wait_q <= 2'h0;
        end else begin
            ack  <= 1'b0;
            data <= ~data;
            perr <= ~perr;
            if (req && !ack) begin
                if (wait_q == 2'h0) begin
                    ack    <= 1'b1;
                    data   <= addr[16:1] ^ 16'h3c5a;
                    perr   <= perr_en && (addr[3:1] == perr_idx);
                    acks   <= acks + 16'h0001;
                    wait_q <= slow ? 2'h3 : 2'h0;
                end else begin
                    wait_q <= wait_q - 2'h1;
                end
            end
        end
    end
endmodule

/* verif/test_dma_read_prefetch_cache.sv */
// self-checking bench for the dma read prefetch cache
// assumes the memory model beside it; status read back over axi4-lite
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_dma_read_prefetch_cache
    import dpc_pkg::*;
();
    logic              clk, sys_rst, pwr_low, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic              s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready, dma_rd_valid, dma_rd_ready, dma_rd_done;
    logic              snoop_wr_valid, mem_rd_req, mem_rd_ack, mem_rd_perr, slow, perr_en;
    logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [ADDR_W-1:0] dma_rd_addr, snoop_wr_addr, mem_rd_addr;
    logic [WORD_W-1:0] dma_rd_data, mem_rd_data;
    logic [2:0]        perr_idx;
    logic [15:0]       acks;
    logic [3:0]        vld;
    logic [1:0]        ord [4];
    int                num_errors = 0;
    int                compares = 0;

    dpc_top u_dpc_top (.clk, .sys_rst, .pwr_low, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dma_rd_valid, .dma_rd_addr,
        .dma_rd_ready, .dma_rd_done, .dma_rd_data, .snoop_wr_valid, .snoop_wr_addr, .mem_rd_req,
        .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .mem_rd_perr);
    dpc_mem_model u_dpc_mem_model (.clk, .rst(sys_rst), .req(mem_rd_req), .addr(mem_rd_addr),
        .ack(mem_rd_ack), .data(mem_rd_data), .perr(mem_rd_perr), .slow, .perr_en, .perr_idx,
        .acks);

    function automatic logic [15:0] md(input logic [21:0] a);
        return a[16:1] ^ 16'h3c5a;
    endfunction
    function automatic logic [21:0] rb();
        return 22'($urandom) & 22'h3ffff0;
    endfunction
    // slot 0 is the next available set, slot 3 the least available
    function automatic void mv(input logic [1:0] s, input bit bk);
        logic [1:0] q[$];
        foreach (ord[i]) if (ord[i] !== s) q.push_back(ord[i]);
        if (bk) q.push_back(s);
        else q.push_front(s);
        foreach (ord[i]) ord[i] = q[i];
    endfunction
    function automatic void clr();
        vld = 4'h0;
        foreach (ord[i]) ord[i] = 2'(i);
    endfunction

    task automatic test_done();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        `CHK(s_axi_bresp, RESP_OKAY)
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk_st();
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(REG_STAT, d, r);
        `CHK(d[12:0], {1'b0, ord[3], ord[2], ord[1], ord[0], vld})
    endtask
    task automatic dma_rd(input logic [21:0] a, output logic [15:0] d);
        dma_rd_addr <= a;
        dma_rd_valid <= 1'b1;
        slow <= 1'($urandom);
        do @(posedge clk); while (dma_rd_ready !== 1'b1);
        dma_rd_valid <= 1'b0;
        do @(posedge clk); while (dma_rd_done !== 1'b1);
        d = dma_rd_data;
        while (dma_rd_ready !== 1'b1) @(posedge clk);
    endtask
    task automatic snoop(input logic [21:0] a);
        snoop_wr_addr <= a;
        snoop_wr_valid <= 1'b1;
        @(posedge clk);
        snoop_wr_valid <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // the whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end

    initial begin
        logic [21:0] b [4];
        logic [1:0]  sk [4];
        logic [21:0] a;
        logic [31:0] d32;
        logic [1:0]  r;
        logic [15:0] d, n;
        void'($urandom(25));
        {pwr_low, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {dma_rd_valid, snoop_wr_valid, slow, perr_en, perr_idx} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, dma_rd_addr, snoop_wr_addr} = '0;
        sys_rst = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        clr();
        chk_st();
        axi_rd(12'h00c, d32, r);
        `CHK(r, RESP_SLVERR)
        a = rb();
        dma_rd(a, d);
        `CHK(d, md(a))
        chk_st();
        $display("test disabled done");
        axi_wr(REG_MCR, 32'h40);
        axi_wr(REG_MEM_MGMT_REG_THREE, 32'h20);
        for (int k = 0; k < 4; k++) begin
            b[k] = rb();
            sk[k] = ord[0];
            n = acks;
            dma_rd(b[k], d);
            `CHK(d, md(b[k]))
            `CHK(acks - n, 16'h0008)
            vld[sk[k]] = 1'b1;
            mv(sk[k], 1'b1);
            chk_st();
        end
        for (int k = 0; k < 4; k++) begin
            a = b[k] | 22'((1 + $urandom % 6) * 2 + $urandom % 2);
            n = acks;
            dma_rd(a, d);
            `CHK(d, md(a))
            `CHK(acks, n)
            mv(sk[k], 1'b1);
            chk_st();
        end
        dma_rd(b[0] | 22'he, d);
        `CHK(d, md(b[0] | 22'he))
        vld[sk[0]] = 1'b0;
        mv(sk[0], 1'b0);
        chk_st();
        a = rb() | 22'h6;
        n = acks;
        dma_rd(a, d);
        `CHK(d, md(a))
        `CHK(acks - n, 16'h0001)
        chk_st();
        $display("test hits done");
        snoop(rb());
        chk_st();
        snoop(b[1] | 22'h9);
        vld[sk[1]] = 1'b0;
        mv(sk[1], 1'b0);
        chk_st();
        perr_en <= 1'b1;
        perr_idx <= 3'($urandom);
        a = rb();
        dma_rd(a, d);
        `CHK(d, md(a))
        chk_st();
        perr_en <= 1'b0;
        $display("test snoop and parity done");
        axi_wr(REG_MEM_MGMT_REG_THREE, 32'h0);
        clr();
        chk_st();
        axi_wr(REG_MEM_MGMT_REG_THREE, 32'h20);
        dma_rd(rb(), d);
        vld[ord[0]] = 1'b1;
        mv(ord[0], 1'b1);
        chk_st();
        pwr_low <= 1'b1;
        @(posedge clk);
        pwr_low <= 1'b0;
        axi_rd(REG_MCR, d32, r);
        `CHK(d32[6:0], MCR_RST)
        clr();
        chk_st();
        $display("test enable done");
        test_done();
    end
endmodule
